// ---- rtl/output_delay_defines.svh ----
`ifndef OUTPUT_DELAY_DEFINES_SVH
`define OUTPUT_DELAY_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFS_OUTPUT0_SEQUENCE_DELAY 8'h0C
`define OFS_OUTPUT1_SEQUENCE_DELAY 8'h0D
`define OFS_OUTPUT2_SEQUENCE_DELAY 8'h0E
`define OFS_OUTPUTS01_DRIVE_CONTROL 8'h0F
`define OFS_OUTPUT2_AND_PINMUX_CONTROL 8'h10

// ****************************************
// Reset values
// ****************************************
`define RST_SEQUENCE_DELAY 8'h00
`define RST_OUTPUTS01_DRIVE_CONTROL 8'hAA
`define RST_OUTPUT2_AND_PINMUX_CONTROL 8'h0A

// ****************************************
// Field positions
// ****************************************
`define FLD_OFF_WAIT_HI 7
`define FLD_OFF_WAIT_LO 4
`define FLD_ON_WAIT_HI 3
`define FLD_ON_WAIT_LO 0
`define FLD_OUT1_OPEN_DRAIN 7
`define FLD_OUT1_GATE_HI 6
`define FLD_OUT1_GATE_LO 5
`define FLD_OUT1_LEVEL 4
`define FLD_OUT0_OPEN_DRAIN 3
`define FLD_OUT0_GATE_HI 2
`define FLD_OUT0_GATE_LO 1
`define FLD_OUT0_LEVEL 0
`define FLD_CLOCK_PIN_FUNCTION_SELECT 5
`define FLD_GOOD_PIN_FUNCTION_SELECT 4
`define FLD_OUT2_OPEN_DRAIN 3
`define FLD_OUT2_GATE_HI 2
`define FLD_OUT2_GATE_LO 1
`define FLD_OUT2_LEVEL 0

// ****************************************
// Timing
// ****************************************
`define CLK_MHZ 250
`define STEP_SHORT_US 500
`define STEP_SHORT_CYCLES (`STEP_SHORT_US * `CLK_MHZ)

`endif

// ---- rtl/output_delay_pkg.sv ----
package output_delay_pkg;

  typedef enum logic [1:0]
  {
    ST_LOW = 2'b00,
    ST_WAIT_ON = 2'b01,
    ST_HIGH = 2'b11,
    ST_WAIT_OFF = 2'b10
  } wait_state_t;

  typedef logic [1:0] gate_source_t;

endpackage : output_delay_pkg

// ---- rtl/output_delay_channel.sv ----
`timescale 1ns/1ps
`include "output_delay_defines.svh"

module output_delay_channel #(
  parameter int STEP_CYCLES = `STEP_SHORT_CYCLES
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic ctrl_i,
  input wire logic [3:0] on_code_i,
  input wire logic [3:0] off_code_i,
  input wire logic on_long_i,
  input wire logic off_long_i,
  output logic level_o
);

  output_delay_pkg::wait_state_t st_r;
  output_delay_pkg::wait_state_t st_nxt;
  logic [18:0] pre_r;
  logic [18:0] pre_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic lvl_r;
  logic lvl_nxt;
  logic [18:0] step_short;
  logic [18:0] limit;
  logic tick;

  // ****************************************
  // Step timer
  // ****************************************
  assign step_short = 19'(STEP_CYCLES);
  // Long steps are twice the short one
  assign limit = (st_r == output_delay_pkg::ST_WAIT_ON) ?
                 (on_long_i ? {step_short[17:0], 1'b0} : step_short) :
                 (off_long_i ? {step_short[17:0], 1'b0} : step_short);
  assign tick = (pre_r == limit - 19'h00001);

  // ****************************************
  // Sequencer
  // ****************************************
  // Codes are read live, so a rewrite mid-wait takes effect at the end of the current step
  always_comb
  begin
    st_nxt = st_r;
    pre_nxt = pre_r + 19'h00001;
    cnt_nxt = cnt_r;
    lvl_nxt = lvl_r;
    unique case (st_r)
      output_delay_pkg::ST_LOW:
      begin
        pre_nxt = 19'h00000;
        cnt_nxt = 4'h0;
        if (ctrl_i)
        begin
          if (on_code_i == 4'h0)
          begin
            st_nxt = output_delay_pkg::ST_HIGH;
            lvl_nxt = 1'b1;
          end
          else
          begin
            st_nxt = output_delay_pkg::ST_WAIT_ON;
          end
        end
      end
      output_delay_pkg::ST_WAIT_ON:
      begin
        if (!ctrl_i)
        begin
          st_nxt = output_delay_pkg::ST_LOW;
        end
        else if (tick)
        begin
          pre_nxt = 19'h00000;
          cnt_nxt = cnt_r + 4'h1;
          if (cnt_r + 4'h1 >= on_code_i)
          begin
            st_nxt = output_delay_pkg::ST_HIGH;
            lvl_nxt = 1'b1;
          end
        end
      end
      output_delay_pkg::ST_HIGH:
      begin
        pre_nxt = 19'h00000;
        cnt_nxt = 4'h0;
        if (!ctrl_i)
        begin
          if (off_code_i == 4'h0)
          begin
            st_nxt = output_delay_pkg::ST_LOW;
            lvl_nxt = 1'b0;
          end
          else
          begin
            st_nxt = output_delay_pkg::ST_WAIT_OFF;
          end
        end
      end
      output_delay_pkg::ST_WAIT_OFF:
      begin
        if (ctrl_i)
        begin
          st_nxt = output_delay_pkg::ST_HIGH;
        end
        else if (tick)
        begin
          pre_nxt = 19'h00000;
          cnt_nxt = cnt_r + 4'h1;
          if (cnt_r + 4'h1 >= off_code_i)
          begin
            st_nxt = output_delay_pkg::ST_LOW;
            lvl_nxt = 1'b0;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      st_r <= output_delay_pkg::ST_LOW;
      pre_r <= 19'h00000;
      cnt_r <= 4'h0;
      lvl_r <= 1'b0;
    end
    else if (ce_i)
    begin
      st_r <= st_nxt;
      pre_r <= pre_nxt;
      cnt_r <= cnt_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  assign level_o = lvl_r;

endmodule : output_delay_channel

// ---- rtl/output_delay_and_drive_control.sv ----
// Function
// - Output zero off wait, bits 7-4, 0.5 ms steps after control falls.
// - Output zero on wait, bits 3-0, 0.5 ms steps after control rises.
// - Startup and shutdown range selects make on and off delay steps 1 ms, up to 15 ms.
// - Output one off wait, bits 7-4, same encoding.
// - Output one on wait, bits 3-0, same encoding.
// - Output two off wait, bits 7-4, 0 to 7.5 ms.
// - Output two on wait, bits 3-0, same sixteen codes.
// - Delay registers at 0Ch, 0Dh, 0Eh reset to zero.
// - Bit 7 picks push-pull or open-drain for shared output one pin.
// - Bits 6-5 gate output one level with nothing or enable pin.
// - Bit 4 is output one software level.
// - Bit 3 picks push-pull or open-drain for output zero.
// - Bits 2-1 gate output zero level with nothing or enable pin.
// - Bit 0 is output zero software level.
// - Control register at 0Fh resets to AAh.
// - Second control register at 10h resets to 0Ah, fields as listed.
// - Bit 5 turns clock input pin into output two.
// - Bit 4 turns power-good pin into output one.
// - Bits 2-1 gate output two level with nothing or enable pin.
// - Bit 3 output two drive type, bit 0 its level.
`timescale 1ns/1ps
`include "output_delay_defines.svh"

module output_delay_and_drive_control #(
  parameter int STEP_CYCLES = `STEP_SHORT_CYCLES
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic startup_range_sel_i,
  input wire logic shutdown_range_sel_i,
  input wire logic enable_pin_one_i,
  input wire logic enable_pin_two_i,
  input wire logic enable_pin_three_i,
  input wire logic power_good_one_i,
  output logic general_output_zero_o,
  output logic general_output_zero_oe_o,
  output logic general_output_one_o,
  output logic general_output_one_oe_o,
  output logic general_output_two_o,
  output logic general_output_two_oe_o,
  output logic [2:0] delayed_levels_o
);

  logic [7:0] delay_r [3];
  logic [7:0] delay_nxt [3];
  logic [7:0] ctl1_r;
  logic [7:0] ctl1_nxt;
  logic [7:0] ctl2_r;
  logic [7:0] ctl2_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [2:0] en_s_nxt;
  logic [2:0] en_filt;
  logic [3:0] en_sel;
  logic [2:0] drive_lvl;
  logic [2:0] pin_used;
  logic [2:0] ctrl;
  logic [2:0] lvl;
  logic [2:0] sw_level;
  logic [2:0] open_drain;
  output_delay_pkg::gate_source_t gate_src [3];
  logic [5:0] pin_nxt;
  logic [5:0] pin_r;
  logic [2:0] lvl_out_r;

  // ****************************************
  // Register file
  // ****************************************
  // Delay registers, one decoder each
  generate
    for (genvar r = 0; r < 3; r++)
    begin : g_delay
      always_comb
      begin
        delay_nxt[r] = delay_r[r];
        if (reg_wr_i && reg_addr_i == `OFS_OUTPUT0_SEQUENCE_DELAY + 8'(r))
        begin
          delay_nxt[r] = reg_wdata_i;
        end
      end

      always_ff @(posedge clk_i)
      begin
        if (sys_rst_i)
        begin
          delay_r[r] <= `RST_SEQUENCE_DELAY;
        end
        else if (ce_i)
        begin
          delay_r[r] <= delay_nxt[r];
        end
      end
    end
  endgenerate

  // Reserved bits are stored, so software reads back what it wrote
  always_comb
  begin
    ctl1_nxt = ctl1_r;
    ctl2_nxt = ctl2_r;
    if (reg_wr_i && reg_addr_i == `OFS_OUTPUTS01_DRIVE_CONTROL)
    begin
      ctl1_nxt = reg_wdata_i;
    end
    if (reg_wr_i && reg_addr_i == `OFS_OUTPUT2_AND_PINMUX_CONTROL)
    begin
      ctl2_nxt = reg_wdata_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      ctl1_r <= `RST_OUTPUTS01_DRIVE_CONTROL;
      ctl2_r <= `RST_OUTPUT2_AND_PINMUX_CONTROL;
    end
    else if (ce_i)
    begin
      ctl1_r <= ctl1_nxt;
      ctl2_r <= ctl2_nxt;
    end
  end

  // Read data holds until the next read; a same-cycle write shows next time
  always_comb
  begin
    rdata_nxt = rdata_r;
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        `OFS_OUTPUT0_SEQUENCE_DELAY: rdata_nxt = delay_r[0];
        `OFS_OUTPUT1_SEQUENCE_DELAY: rdata_nxt = delay_r[1];
        `OFS_OUTPUT2_SEQUENCE_DELAY: rdata_nxt = delay_r[2];
        `OFS_OUTPUTS01_DRIVE_CONTROL: rdata_nxt = ctl1_r;
        `OFS_OUTPUT2_AND_PINMUX_CONTROL: rdata_nxt = ctl2_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      rdata_r <= 8'h00;
    end
    else if (ce_i)
    begin
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************
  // Enable pin synchronisers
  // ****************************************
  // Pins are asynchronous; accept a change only once two stages agree
  assign en_s_nxt = {enable_pin_three_i, enable_pin_two_i, enable_pin_one_i};

  generate
    for (genvar b = 0; b < 3; b++)
    begin : g_sync
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic hold_r;
      logic hold_nxt;

      always_comb
      begin
        hold_nxt = hold_r;
        if (s2_r == s3_r)
        begin
          hold_nxt = s3_r;
        end
      end

      always_ff @(posedge clk_i)
      begin
        if (sys_rst_i)
        begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
          s3_r <= 1'b0;
          hold_r <= 1'b0;
        end
        else if (ce_i)
        begin
          s1_r <= en_s_nxt[b];
          s2_r <= s1_r;
          s3_r <= s2_r;
          hold_r <= hold_nxt;
        end
      end

      assign en_filt[b] = hold_r;
    end
  endgenerate

  // Entry zero stands for no gating, so every source code has a defined pick
  assign en_sel = {en_filt, 1'b1};

  // ****************************************
  // Field decode
  // ****************************************
  assign sw_level[0] = ctl1_r[`FLD_OUT0_LEVEL];
  assign sw_level[1] = ctl1_r[`FLD_OUT1_LEVEL];
  assign sw_level[2] = ctl2_r[`FLD_OUT2_LEVEL];
  assign open_drain[0] = ctl1_r[`FLD_OUT0_OPEN_DRAIN];
  assign open_drain[1] = ctl1_r[`FLD_OUT1_OPEN_DRAIN];
  assign open_drain[2] = ctl2_r[`FLD_OUT2_OPEN_DRAIN];
  assign gate_src[0] = ctl1_r[`FLD_OUT0_GATE_HI:`FLD_OUT0_GATE_LO];
  assign gate_src[1] = ctl1_r[`FLD_OUT1_GATE_HI:`FLD_OUT1_GATE_LO];
  assign gate_src[2] = ctl2_r[`FLD_OUT2_GATE_HI:`FLD_OUT2_GATE_LO];

  // ****************************************
  // Delay channels
  // ****************************************
  generate
    for (genvar k = 0; k < 3; k++)
    begin : g_chan
      // Source zero means the level bit alone
      assign ctrl[k] = sw_level[k] & en_sel[gate_src[k]];

      output_delay_channel #(
        .STEP_CYCLES(STEP_CYCLES)
      ) u_chan (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .ctrl_i(ctrl[k]),
        .on_code_i(delay_r[k][`FLD_ON_WAIT_HI:`FLD_ON_WAIT_LO]),
        .off_code_i(delay_r[k][`FLD_OFF_WAIT_HI:`FLD_OFF_WAIT_LO]),
        .on_long_i(startup_range_sel_i),
        .off_long_i(shutdown_range_sel_i),
        .level_o(lvl[k])
      );
    end
  endgenerate

  // ****************************************
  // Pin drivers
  // ****************************************
  // Power-good keeps the pin until handed over; bit 7 sets its drive type either way
  assign drive_lvl = {lvl[2], ctl2_r[`FLD_GOOD_PIN_FUNCTION_SELECT] ? lvl[1] : power_good_one_i, lvl[0]};
  // Clock input mode leaves the pin undriven
  assign pin_used = {ctl2_r[`FLD_CLOCK_PIN_FUNCTION_SELECT], 2'b11};

  generate
    for (genvar i = 0; i < 3; i++)
    begin : g_pin
      logic o_nxt;
      logic oe_nxt;

      always_comb
      begin
        o_nxt = 1'b0;
        oe_nxt = 1'b0;
        if (pin_used[i] && open_drain[i])
        begin
          // Never drive high, the pull-up owns that level
          oe_nxt = ~drive_lvl[i];
        end
        else if (pin_used[i])
        begin
          o_nxt = drive_lvl[i];
          oe_nxt = 1'b1;
        end
      end

      assign pin_nxt[2 * i] = o_nxt;
      assign pin_nxt[2 * i + 1] = oe_nxt;
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      pin_r <= 6'h00;
      lvl_out_r <= 3'h0;
    end
    else if (ce_i)
    begin
      pin_r <= pin_nxt;
      lvl_out_r <= lvl;
    end
  end

  assign reg_rdata_o = rdata_r;
  assign general_output_zero_o = pin_r[0];
  assign general_output_zero_oe_o = pin_r[1];
  assign general_output_one_o = pin_r[2];
  assign general_output_one_oe_o = pin_r[3];
  assign general_output_two_o = pin_r[4];
  assign general_output_two_oe_o = pin_r[5];
  assign delayed_levels_o = lvl_out_r;

endmodule : output_delay_and_drive_control

// ---- tb/output_delay_chk.sv ----
`timescale 1ns/1ps
module output_delay_chk (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic general_output_zero_o,
  input wire logic general_output_zero_oe_o,
  input wire logic general_output_two_o,
  input wire logic general_output_two_oe_o,
  input wire logic [2:0] delayed_levels_o
);
  // ****
  // Checks
  // ****
  default clocking cb @(posedge clk_i);
  endclocking
  logic hole;
  assign hole = reg_addr_i < 8'h0C || reg_addr_i > 8'h10;
  reset_clear_a: assert property (sys_rst_i && ce_i |=> reg_rdata_o == 8'h00 && !general_output_zero_oe_o)
    else $error("reset state wrong");
  hole_read_a: assert property (disable iff (sys_rst_i) ce_i && reg_rd_i && hole |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  write_read_a: assert property (disable iff (sys_rst_i)
    ce_i && reg_wr_i && reg_addr_i == 8'h0C ##1 ce_i && reg_rd_i && !reg_wr_i && reg_addr_i == 8'h0C
    |=> reg_rdata_o == $past(reg_wdata_i, 2)) else $error("read back differs");
  // First edge after reset still shows the reset pin state
  zero_release_a: assert property (disable iff (sys_rst_i)
    !$past(sys_rst_i) && !general_output_zero_oe_o |-> !general_output_zero_o && delayed_levels_o[0])
    else $error("pin zero released while low");
  zero_high_a: assert property (disable iff (sys_rst_i)
    general_output_zero_o |-> general_output_zero_oe_o && delayed_levels_o[0]) else $error("pin zero high wrongly");
  two_high_a: assert property (disable iff (sys_rst_i)
    general_output_two_o |-> general_output_two_oe_o && delayed_levels_o[2]) else $error("pin two high wrongly");
  freeze_a: assert property (disable iff (sys_rst_i)
    !ce_i |=> $stable(delayed_levels_o) && $stable(reg_rdata_o)) else $error("state moved while frozen");
  level_ce_a: assert property (disable iff (sys_rst_i)
    !$past(sys_rst_i) && $changed(delayed_levels_o) |-> $past(ce_i)) else $error("level moved without enable");
  cover property (ce_i && reg_rd_i && hole);
  cover property ($rose(delayed_levels_o[0]));
  cover property ($fell(delayed_levels_o[2]));
endmodule : output_delay_chk

// ---- tb/output_load.sv ----
`timescale 1ns/1ps
module output_load (
  input wire logic [2:0] pin_o_i,
  input wire logic [2:0] pin_oe_i,
  output logic [2:0] wire_o
);
  // ****
  // Pull-ups
  // ****
  // Released line floats up, so open-drain high reads as 1
  assign wire_o = (pin_oe_i & pin_o_i) | ~pin_oe_i;
endmodule : output_load

// ---- tb/output_delay_and_drive_control_tb.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; $display("MISMATCH %0t got %h want %h", $time, a, b); end end
module output_delay_and_drive_control_tb;
  localparam int STEP = 4;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic [1:0] rng = 2'b00;
  logic [3:0] en = 4'h0;
  logic pg = 1'b0;
  logic [2:0] po;
  logic [2:0] poe;
  logic [2:0] dl;
  logic [2:0] wl;
  logic [2:0] od = 3'b000;
  logic [2:0] lvl = 3'b000;
  logic [1:0] src [3] = '{2'h0, 2'h0, 2'h0};
  logic [1:0] sel = 2'b11;
  logic [7:0] rv [5] = '{8'h00, 8'h00, 8'h00, 8'hAA, 8'h0A};
  int tk [5] = '{0, 0, 1, 2, 1};
  int ton [5] = '{1, 3, 15, 0, 2};
  int tof [5] = '{2, 1, 0, 15, 4};
  logic [1:0] trg [5] = '{2'b00, 2'b01, 2'b10, 2'b00, 2'b11};
  int n;
  int fail_count = 0;
  int total_checks = 0;
  output_delay_and_drive_control #(.STEP_CYCLES(STEP)) output_delay_and_drive_control_i (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .startup_range_sel_i(rng[0]),
    .shutdown_range_sel_i(rng[1]), .enable_pin_one_i(en[1]), .enable_pin_two_i(en[2]), .enable_pin_three_i(en[3]),
    .power_good_one_i(pg), .general_output_zero_o(po[0]), .general_output_zero_oe_o(poe[0]),
    .general_output_one_o(po[1]), .general_output_one_oe_o(poe[1]), .general_output_two_o(po[2]),
    .general_output_two_oe_o(poe[2]), .delayed_levels_o(dl));
  output_load output_load_i (.pin_o_i(po), .pin_oe_i(poe), .wire_o(wl));
  initial
  begin
    forever #2 clk_i = ~clk_i;
  end
  // ****
  // Access tasks, entered at a falling edge
  // ****
  // Strobes stay up between accesses so no signal is set twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_rd_i = 1'b0;
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(negedge clk_i);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b1;
    reg_addr_i = a;
    @(negedge clk_i);
    `CHK(reg_rdata_o, e)
  endtask : rd
  task automatic ctl(input int k);
    if (k < 2)
      wr(8'h0F, {od[1], src[1], lvl[1], od[0], src[0], lvl[0]});
    else
      wr(8'h10, {2'b00, sel[1], sel[0], od[2], src[2], lvl[2]});
  endtask : ctl
  task automatic wt(input int k, input logic v, output int c);
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    c = 0;
    while (dl[k] !== v && c < 400)
    begin
      @(negedge clk_i);
      c++;
    end
    if (c >= 400)
    begin
      fail_count++;
      $display("MISMATCH %0t output wait timed out", $time);
      print_verdict();
    end
    `CHK(wl[k], v)
    `CHK(poe[k], od[k] ? !v : 1'b1)
  endtask : wt
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict
  initial
  begin
    repeat (8) @(negedge clk_i);
    sys_rst_i = 1'b0;
    for (int i = 0; i < 5; i++)
      rd(8'h0C + 8'(i), rv[i]);
    $display("test reset done");
    for (int i = 0; i < 5; i++)
    begin
      wr(8'h0C + 8'(i), 8'hC5 ^ 8'(i * 17));
      rd(8'h0C + 8'(i), 8'hC5 ^ 8'(i * 17));
    end
    wr(8'h11, 8'h55);
    rd(8'h11, 8'h00);
    ce_i = 1'b0;
    wr(8'h0C, 8'hFF);
    ce_i = 1'b1;
    rd(8'h0C, 8'hC5);
    $display("test regs done");
    ctl(2);
    for (int i = 0; i < 5; i++)
    begin
      rng = trg[i];
      od[tk[i]] = i[0];
      ctl(tk[i]);
      wr(8'h0C + 8'(tk[i]), {tof[i][3:0], ton[i][3:0]});
      lvl[tk[i]] = 1'b1;
      ctl(tk[i]);
      wt(tk[i], 1'b1, n);
      `CHK(n, ton[i] * STEP * (trg[i][0] ? 2 : 1) + 2)
      lvl[tk[i]] = 1'b0;
      ctl(tk[i]);
      wt(tk[i], 1'b0, n);
      `CHK(n, tof[i] * STEP * (trg[i][1] ? 2 : 1) + 2)
    end
    rng = 2'b00;
    wr(8'h0C, 8'hF5);
    lvl[0] = 1'b1;
    ctl(0);
    repeat (8) @(negedge clk_i);
    lvl[0] = 1'b0;
    ctl(0);
    repeat (30) @(negedge clk_i);
    `CHK(dl[0], 1'b0)
    lvl[0] = 1'b1;
    ctl(0);
    wt(0, 1'b1, n);
    `CHK(n, 5 * STEP + 2)
    lvl[0] = 1'b0;
    ctl(0);
    wt(0, 1'b0, n);
    `CHK(n, 15 * STEP + 2)
    $display("test delays done");
    for (int k = 0; k < 3; k++)
      wr(8'h0C + 8'(k), 8'h00);
    for (int k = 0; k < 3; k++)
    begin
      for (int s = 1; s < 4; s++)
      begin
        src[k] = s[1:0];
        lvl[k] = 1'b1;
        ctl(k);
        repeat (12) @(negedge clk_i);
        `CHK(dl[k], 1'b0)
        en[s] = 1'b1;
        wt(k, 1'b1, n);
        en[s] = 1'b0;
        wt(k, 1'b0, n);
      end
      lvl[k] = 1'b0;
      src[k] = 2'h0;
      ctl(k);
    end
    $display("test gates done");
    sel = 2'b00;
    lvl[2] = 1'b1;
    ctl(2);
    for (int d = 0; d < 2; d++)
      for (int p = 0; p < 2; p++)
      begin
        od[1] = d[0];
        pg = p[0];
        ctl(0);
        repeat (4) @(negedge clk_i);
        `CHK(wl[1], p[0])
        `CHK(poe[1], d[0] ? !p[0] : 1'b1)
        `CHK(poe[2], 1'b0)
      end
    $display("test pin select done");
    print_verdict();
  end
endmodule : output_delay_and_drive_control_tb
bind output_delay_and_drive_control output_delay_chk output_delay_chk_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .ce_i(ce_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .general_output_zero_o(general_output_zero_o),
  .general_output_zero_oe_o(general_output_zero_oe_o), .general_output_two_o(general_output_two_o),
  .general_output_two_oe_o(general_output_two_oe_o), .delayed_levels_o(delayed_levels_o));
